// [dmr_pkg.sv]
// Package: data-memory map constants and carrier types
// Functional notes
// - Data space splits into user RAM with stack and a control page.
// - User RAM is 192 eight-bit bytes that the CPU reads and writes.
// - Control registers are decoded from 0c0h to 0ffh inclusive.
// - Bit-and-byte registers other than the read-only ADC result take bit set, bit clear and byte access.
// - Shared addresses are steered by direction and timer or PWM mode.
// - A byte write of 09h to clock control selects divide-by-16.
package dmr_pkg;

  // ----------------------------------------------------------------
  // Memory regions
  // ----------------------------------------------------------------
  localparam int         RAM_BYTES = 192;
  localparam logic [7:0] CTL_BASE  = 8'hc0;
  localparam logic [7:0] CTL_LAST  = 8'hff;

  // ----------------------------------------------------------------
  // Control register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_PA_DATA = 8'hc0;
  localparam logic [7:0] A_PA_DIR  = 8'hc1;
  localparam logic [7:0] A_PB_DATA = 8'hc2;
  localparam logic [7:0] A_PB_DIR  = 8'hc3;
  localparam logic [7:0] A_PC_DATA = 8'hc4;
  localparam logic [7:0] A_PC_DIR  = 8'hc5;
  localparam logic [7:0] A_PD_DATA = 8'hc6;
  localparam logic [7:0] A_PD_DIR  = 8'hc7;
  localparam logic [7:0] A_PA_FUNC = 8'hca;
  localparam logic [7:0] A_PB_FUNC = 8'hcb;
  localparam logic [7:0] A_PULLUP  = 8'hcc;
  localparam logic [7:0] A_PD_FUNC = 8'hcd;
  localparam logic [7:0] A_TM0     = 8'hd0;
  localparam logic [7:0] A_T0      = 8'hd1;
  localparam logic [7:0] A_TM1     = 8'hd2;
  localparam logic [7:0] A_T1CMP   = 8'hd3;
  localparam logic [7:0] A_T1      = 8'hd4;
  localparam logic [7:0] A_PWM0HI  = 8'hd5;
  localparam logic [7:0] A_TM2     = 8'hd6;
  localparam logic [7:0] A_T2      = 8'hd7;
  localparam logic [7:0] A_TM3     = 8'hd8;
  localparam logic [7:0] A_T3CMP   = 8'hd9;
  localparam logic [7:0] A_T3      = 8'hda;
  localparam logic [7:0] A_PWM1HI  = 8'hdb;
  localparam logic [7:0] A_BUZZ    = 8'hde;
  localparam logic [7:0] A_SMODE   = 8'he0;
  localparam logic [7:0] A_SDATA   = 8'he1;
  localparam logic [7:0] A_IRQ_ENABLE_HIGH    = 8'he2;
  localparam logic [7:0] A_IRQ_ENABLE_LOW    = 8'he3;
  localparam logic [7:0] A_IRQ_REQUEST_HIGH    = 8'he4;
  localparam logic [7:0] A_IEDGE   = 8'he6;
  localparam logic [7:0] A_ADC_MODE    = 8'hea;
  localparam logic [7:0] A_ADC_RESULT    = 8'heb;
  localparam logic [7:0] A_CLKCTL  = 8'hec;
  localparam logic [7:0] A_WDT     = 8'hed;
  localparam logic [7:0] A_PFD     = 8'hef;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_UNDEF   = 8'h00;
  localparam logic [7:0] RST_PA_DIR  = 8'h00;
  localparam logic [7:0] RST_PB_DIR  = 8'h00;
  localparam logic [7:0] RST_PA_FUNC = 8'h00;
  localparam logic [7:0] RST_PB_FUNC = 8'h00;
  localparam logic [7:0] RST_BUZZ    = 8'hff;
  localparam logic [7:0] RST_SMODE   = 8'h01;
  localparam logic [7:0] RST_ADC_MODE    = 8'h01;
  localparam logic [7:0] RST_CLKCTL  = 8'h17;
  localparam logic [7:0] RST_WDT     = 8'h7f;
  localparam logic [7:0] RST_PFD     = 8'h04;

  // ----------------------------------------------------------------
  // Mode fields
  // ----------------------------------------------------------------
  localparam int         CAP_BIT_EVEN = 5;
  localparam int         CAP_BIT_ODD  = 4;
  localparam int         PWM_EN_BIT   = 5;
  localparam logic [2:0] BTS_DIV16    = 3'h1;
  localparam logic [7:0] CLK_DIV16    = 8'h09;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       we;
    logic       bit_op;
    logic       bit_set;
    logic [2:0] bit_idx;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dmr_req_t;

  typedef struct packed {
    logic [7:0] timer0_count;
    logic [7:0] timer0_capture_data;
    logic [7:0] timer1_count;
    logic [7:0] timer1_capture_data;
    logic [7:0] timer2_count;
    logic [7:0] timer2_capture_data;
    logic [7:0] timer3_count;
    logic [7:0] timer3_capture_data;
    logic [7:0] interval_count;
    logic [7:0] adc_result;
  } dmr_pin_t;

endpackage

// [dmr_core.sv]
// Data-memory decode: user RAM and control register page
`timescale 1ns/100ps
module dmr_core
  import dmr_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire dmr_req_t         req,
  input  wire dmr_pin_t         pin,
  output logic      [7:0]       rd_data,
  output logic                  rd_valid,
  output logic      [63:0][7:0] ctl_regs,
  output logic      [7:0]       pwm0_period,
  output logic      [7:0]       pwm1_period
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic is_impl(input logic [7:0] a);
    case (a)
      A_PA_DATA, A_PA_DIR, A_PB_DATA, A_PB_DIR, A_PC_DATA, A_PC_DIR,
      A_PD_DATA, A_PD_DIR, A_PA_FUNC, A_PB_FUNC, A_PULLUP, A_PD_FUNC,
      A_TM0, A_T0, A_TM1, A_T1CMP, A_T1, A_PWM0HI, A_TM2, A_T2,
      A_TM3, A_T3CMP, A_T3, A_PWM1HI, A_BUZZ, A_SMODE, A_SDATA,
      A_IRQ_ENABLE_HIGH, A_IRQ_ENABLE_LOW, A_IRQ_REQUEST_HIGH, A_IEDGE, A_ADC_MODE, A_ADC_RESULT, A_CLKCTL,
      A_WDT, A_PFD: is_impl = 1'b1;
      default:      is_impl = 1'b0;
    endcase
  endfunction

  function automatic logic is_wo(input logic [7:0] a);
    case (a)
      A_PD_DIR, A_PA_FUNC, A_PB_FUNC, A_PULLUP, A_PD_FUNC,
      A_T1CMP, A_PWM0HI, A_T3CMP, A_PWM1HI, A_BUZZ: is_wo = 1'b1;
      default:                                      is_wo = 1'b0;
    endcase
  endfunction

  function automatic logic is_bitable(input logic [7:0] a);
    case (a)
      A_PA_DATA, A_PB_DATA, A_PB_DIR, A_PC_DATA, A_PC_DIR, A_PD_DATA,
      A_TM0, A_TM1, A_TM2, A_TM3, A_SMODE, A_SDATA, A_IRQ_ENABLE_HIGH, A_IRQ_ENABLE_LOW,
      A_IRQ_REQUEST_HIGH, A_IEDGE, A_ADC_MODE, A_ADC_RESULT: is_bitable = 1'b1;
      default:                         is_bitable = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      A_PA_DIR:  rst_val = RST_PA_DIR;
      A_PB_DIR:  rst_val = RST_PB_DIR;
      A_PA_FUNC: rst_val = RST_PA_FUNC;
      A_PB_FUNC: rst_val = RST_PB_FUNC;
      A_BUZZ:    rst_val = RST_BUZZ;
      A_SMODE:   rst_val = RST_SMODE;
      A_ADC_MODE:    rst_val = RST_ADC_MODE;
      A_CLKCTL:  rst_val = RST_CLKCTL;
      A_WDT:     rst_val = RST_WDT;
      A_PFD:     rst_val = RST_PFD;
      default:   rst_val = RST_UNDEF;
    endcase
  endfunction

  function automatic logic [7:0] bit_mod(input logic [7:0] cur,
                                         input logic       set,
                                         input logic [2:0] idx);
    logic [7:0] m;
    m = 8'h01 << idx;
    bit_mod = set ? (cur | m) : (cur & ~m);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]       ram_r [0:RAM_BYTES-1];
  logic [63:0][7:0] ctl_r;
  logic [7:0]       per0_r;
  logic [7:0]       per1_r;
  logic [7:0]       rdata_r;
  logic [7:0]       rdata_nxt;
  logic             rvalid_r;

  // ----------------------------------------------------------------
  // Address and mode decode
  // ----------------------------------------------------------------
  wire logic [7:0] addr      = req.addr;
  wire logic [5:0] slot      = addr[5:0];
  wire logic       is_ram    = (addr < 8'(RAM_BYTES));
  wire logic       is_ctl    = (addr >= CTL_BASE) &&
                               (addr <= CTL_LAST);
  wire logic [7:0] ram_idx   = is_ram ? addr : 8'h00;
  wire logic [7:0] ram_cur   = ram_r[ram_idx];
  wire logic [7:0] ctl_cur   = ctl_r[slot];
  wire logic       cap0_on   = ctl_r[A_TM0[5:0]][CAP_BIT_EVEN];
  wire logic       cap1_on   = ctl_r[A_TM1[5:0]][CAP_BIT_ODD];
  wire logic       pwm0_on   = ctl_r[A_TM1[5:0]][PWM_EN_BIT];
  wire logic       cap2_on   = ctl_r[A_TM2[5:0]][CAP_BIT_EVEN];
  wire logic       cap3_on   = ctl_r[A_TM3[5:0]][CAP_BIT_ODD];
  wire logic       pwm1_on   = ctl_r[A_TM3[5:0]][PWM_EN_BIT];

  // ----------------------------------------------------------------
  // Write steering
  // ----------------------------------------------------------------
  wire logic       bit_ok    = is_ram || is_bitable(addr);
  wire logic       wr_go     = clk_en && req.valid && req.we &&
                               (!req.bit_op || bit_ok);
  wire logic [7:0] cur_byte  = is_ram ? ram_cur : ctl_cur;
  wire logic [7:0] new_byte  = req.bit_op ?
                               bit_mod(cur_byte, req.bit_set, req.bit_idx) :
                               req.wdata;
  wire logic       to_per0   = (addr == A_T1CMP) && pwm0_on;
  wire logic       to_per1   = (addr == A_T3CMP) && pwm1_on;
  wire logic       duty_gate = ((addr != A_T1) || pwm0_on) &&
                               ((addr != A_T3) || pwm1_on);
  wire logic       ctl_wok   = is_impl(addr) && (addr != A_ADC_RESULT) &&
                               !to_per0 && !to_per1 && duty_gate;
  wire logic       ram_we    = wr_go && is_ram;
  wire logic       ctl_we    = wr_go && is_ctl && ctl_wok;
  wire logic       per0_we   = wr_go && to_per0;
  wire logic       per1_we   = wr_go && to_per1;

  // ----------------------------------------------------------------
  // Read steering
  // ----------------------------------------------------------------
  wire logic [7:0] rd_t0     = cap0_on ? pin.timer0_capture_data :
                               pin.timer0_count;
  wire logic [7:0] rd_t1     = pwm0_on ? ctl_r[A_T1[5:0]] :
                               cap1_on ? pin.timer1_capture_data :
                               pin.timer1_count;
  wire logic [7:0] rd_t2     = cap2_on ? pin.timer2_capture_data :
                               pin.timer2_count;
  wire logic [7:0] rd_t3     = pwm1_on ? ctl_r[A_T3[5:0]] :
                               cap3_on ? pin.timer3_capture_data :
                               pin.timer3_count;
  wire logic [7:0] rd_ctl    = (addr == A_T0)     ? rd_t0 :
                               (addr == A_T1)     ? rd_t1 :
                               (addr == A_T2)     ? rd_t2 :
                               (addr == A_T3)     ? rd_t3 :
                               (addr == A_ADC_RESULT)   ? pin.adc_result :
                               (addr == A_CLKCTL) ? pin.interval_count :
                               (!is_impl(addr) || is_wo(addr)) ? 8'h00 :
                               ctl_cur;
  wire logic       rd_go     = clk_en && req.valid && !req.we;

  always_comb begin
    if (is_ram) begin
      rdata_nxt = ram_cur;
    end else if (is_ctl) begin
      rdata_nxt = rd_ctl;
    end else begin
      rdata_nxt = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // User RAM
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram_r[ram_idx] <= new_byte;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (clk_en && sys_rst) begin
      for (int i = 0; i < 64; i++) begin
        ctl_r[i] <= rst_val(CTL_BASE | 8'(i));
      end
    end else if (ctl_we) begin
      ctl_r[slot] <= new_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en && sys_rst) begin
      per0_r <= RST_UNDEF;
      per1_r <= RST_UNDEF;
    end else begin
      if (per0_we) begin
        per0_r <= req.wdata;
      end
      if (per1_we) begin
        per1_r <= req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (clk_en) begin
      if (sys_rst) begin
        rdata_r  <= 8'h00;
        rvalid_r <= 1'b0;
      end else begin
        rvalid_r <= rd_go;
        if (rd_go) begin
          rdata_r <= rdata_nxt;
        end
      end
    end
  end

  assign rd_data     = rdata_r;
  assign rd_valid    = rvalid_r;
  assign ctl_regs    = ctl_r;
  assign pwm0_period = per0_r;
  assign pwm1_period = per1_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ram_write_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    ram_we && !req.bit_op |=> ram_r[$past(ram_idx)] == $past(req.wdata))
    else $error("RAM byte write not stored");

  ram_read_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_go && is_ram |=> rd_valid && rd_data == $past(ram_cur))
    else $error("RAM read data wrong");

  ctl_write_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    ctl_we && !req.bit_op |=> ctl_r[$past(slot)] == $past(req.wdata))
    else $error("Control byte write not stored");

  bit_set_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_go && is_ctl && req.bit_op && req.bit_set && ctl_we
    |=> ctl_r[$past(slot)][$past(req.bit_idx)])
    else $error("Bit set not applied");

  bit_only_one_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    ctl_we && req.bit_op
    |=> (ctl_r[$past(slot)] ^ $past(ctl_cur)) ==
        (8'h01 << $past(req.bit_idx)) ||
        ctl_r[$past(slot)] == $past(ctl_cur))
    else $error("Bit op changed other bits");

  byte_only_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && req.valid && req.we && req.bit_op && is_ctl &&
    !is_bitable(addr) |=> $stable(ctl_r))
    else $error("Bit op on byte-only register took effect");

  duty_read_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_go && addr == A_T1 && pwm0_on
    |=> rd_data == $past(ctl_r[A_T1[5:0]]))
    else $error("Duty read in PWM mode wrong");

  count_read_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_go && addr == A_T0 && !cap0_on
    |=> rd_data == $past(pin.timer0_count))
    else $error("Timer0 count read wrong");

  interval_read_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_go && addr == A_CLKCTL
    |=> rd_data == $past(pin.interval_count))
    else $error("Interval count read wrong");

  period_route_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    per0_we |=> pwm0_period == $past(req.wdata) &&
                ctl_r[A_T1CMP[5:0]] == $past(ctl_r[A_T1CMP[5:0]]))
    else $error("PWM0 period write misrouted");

  div16_sel_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_go && !req.bit_op && addr == A_CLKCTL && req.wdata == CLK_DIV16
    |=> ctl_r[A_CLKCTL[5:0]][2:0] == BTS_DIV16)
    else $error("Divide-by-16 not selected");

  reset_vals_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) && $past(clk_en)
    |-> ctl_r[A_WDT[5:0]] == RST_WDT && ctl_r[A_BUZZ[5:0]] == RST_BUZZ &&
        ctl_r[A_PFD[5:0]] == RST_PFD && !rd_valid)
    else $error("Reset values not loaded");

  rd_pulse_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && !rd_go
    |=> !rd_valid)
    else $error("Read strobe held too long");

  freeze_hold_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !clk_en
    |=> $stable(ctl_r) && $stable(rd_valid) && $stable(rd_data))
    else $error("State moved while frozen");

  wo_read_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_go && is_wo(addr)
    |=> rd_data == 8'h00)
    else $error("Write-only place read not zero");

  unimpl_read_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_go && is_ctl && !is_impl(addr)
    |=> rd_data == 8'h00)
    else $error("Unassigned place read not zero");

  duty_block_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_go && ((addr == A_T1 && !pwm0_on) || (addr == A_T3 && !pwm1_on))
    |=> $stable(ctl_r))
    else $error("Duty written outside PWM mode");

  cmp_store_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_go && !req.bit_op && addr == A_T1CMP && !pwm0_on
    |=> ctl_r[A_T1CMP[5:0]] == $past(req.wdata) && $stable(pwm0_period))
    else $error("Timer1 compare write misrouted");

  period1_route_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    per1_we |=> pwm1_period == $past(req.wdata) &&
                ctl_r[A_T3CMP[5:0]] == $past(ctl_r[A_T3CMP[5:0]]))
    else $error("PWM1 period write misrouted");

  capture_read_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_go && addr == A_T1 && !pwm0_on && cap1_on
    |=> rd_data == $past(pin.timer1_capture_data))
    else $error("Capture1 read wrong");

  cap0_read_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_go && addr == A_T0 && cap0_on
    |=> rd_data == $past(pin.timer0_capture_data))
    else $error("Capture0 read wrong");

  t2_read_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_go && addr == A_T2
    |=> rd_data == $past(cap2_on ? pin.timer2_capture_data :
                                   pin.timer2_count))
    else $error("Timer2 read wrong");

  t3_read_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_go && addr == A_T3 && !pwm1_on
    |=> rd_data == $past(cap3_on ? pin.timer3_capture_data :
                                   pin.timer3_count))
    else $error("Timer3 read wrong");

  adc_read_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_go && addr == A_ADC_RESULT
    |=> rd_data == $past(pin.adc_result))
    else $error("Conversion result read wrong");

  per_reset_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) && $past(clk_en)
    |-> pwm0_period == RST_UNDEF && pwm1_period == RST_UNDEF &&
        rd_data == 8'h00)
    else $error("Period or read data not reset");

  ram_bit_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    ram_we && req.bit_op
    |=> ram_r[$past(ram_idx)][$past(req.bit_idx)] == $past(req.bit_set))
    else $error("RAM bit op not applied");

  bit_clr_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    ctl_we && req.bit_op && !req.bit_set
    |=> !ctl_r[$past(slot)][$past(req.bit_idx)])
    else $error("Bit clear not applied");

endmodule

// [dmr_cpu_model.sv]
// CPU-side model issuing byte writes, bit writes and reads
`timescale 1ns/100ps
module dmr_cpu_model
  import dmr_pkg::*;
(
  input  wire logic       clk,
  output dmr_req_t        req,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  initial req = '0;

  // ------------------------------------------------------------
  // Request issue, changed only at the falling edge
  // ------------------------------------------------------------
  task automatic issue(input logic w, input logic b, input logic s,
                       input logic [2:0] i, input logic [7:0] a,
                       input logic [7:0] wd);
    @(negedge clk);
    req = '{valid: 1'b1, we: w, bit_op: b, bit_set: s,
            bit_idx: i, addr: a, wdata: wd};
  endtask

  // Whole-byte write, the only form used on write-only places
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    issue(1'b1, 1'b0, 1'b0, 3'h0, a, wd);
  endtask

  // Bit set or clear, aimed only at bit-capable places
  task automatic bit_wr(input logic [7:0] a, input logic s,
                        input logic [2:0] i);
    issue(1'b1, 1'b1, s, i, a, 8'h00);
  endtask

  // Read; unassigned places are read but their data not trusted
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    issue(1'b0, 1'b0, 1'b0, 3'h0, a, 8'h00);
    @(negedge clk);
    req.valid = 1'b0;
    v = rd_valid;
    d = rd_data;
  endtask

  task automatic idle;
    @(negedge clk);
    req.valid = 1'b0;
  endtask

  // Divide-by-16 for the interval clock, as a whole byte
  task automatic set_div16;
    wr(A_CLKCTL, CLK_DIV16);
  endtask
endmodule

// [dmr_core_tb.sv]
// Self-checking bench for the data-memory decode
`timescale 1ns/100ps
module dmr_core_tb
  import dmr_pkg::*;
  ;
  localparam logic [7:0] RST_A [10] = '{8'hc1, 8'hc3, 8'hca, 8'hcb,
    8'hde, 8'he0, 8'hea, 8'hec, 8'hed, 8'hef};
  localparam logic [7:0] RST_V [10] = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'hff, 8'h01, 8'h01, 8'h17, 8'h7f, 8'h04};
  localparam logic [7:0] BIT_A [11] = '{8'hc0, 8'hc2, 8'hc3, 8'hc4,
    8'hc5, 8'hc6, 8'he1, 8'he2, 8'he3, 8'he4, 8'he6};
  localparam logic [7:0] WO_A [6] = '{8'hca, 8'hcb, 8'hcc, 8'hcd,
    8'hd5, 8'hde};

  logic             clk;
  logic             sys_rst;
  logic             clk_en;
  dmr_req_t         req;
  dmr_pin_t         pin;
  logic [7:0]       rd_data;
  logic             rd_valid;
  logic [63:0][7:0] ctl_regs;
  logic [7:0]       pwm0_period;
  logic [7:0]       pwm1_period;
  logic [7:0]       d;
  logic             v;
  int               fails = 0;
  int               checks = 0;
  int               cycles = 0;

  dmr_core i_dmr_core (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en),
    .req         (req),
    .pin         (pin),
    .rd_data     (rd_data),
    .rd_valid    (rd_valid),
    .ctl_regs    (ctl_regs),
    .pwm0_period (pwm0_period),
    .pwm1_period (pwm1_period)
  );

  dmr_cpu_model i_dmr_cpu_model (
    .clk      (clk),
    .req      (req),
    .rd_data  (rd_data),
    .rd_valid (rd_valid)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // ------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      close_out;
    end
  end

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [7:0] e);
    i_dmr_cpu_model.rd(a, d, v);
    chk({n, " strobe"}, 8'h01, {7'h00, v});
    chk(n, e, d);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 10; i++) begin
      chk("reset value", RST_V[i], ctl_regs[RST_A[i][5:0]]);
    end
    rchk("serial mode", A_SMODE, 8'h01);
  endtask

  task automatic t_ram;
    logic [7:0] a;
    for (a = 8'h00; a < 8'hc0; a++) begin
      i_dmr_cpu_model.wr(a, a ^ 8'h5a);
    end
    i_dmr_cpu_model.wr(A_PA_DATA, 8'h33);
    for (a = 8'h00; a < 8'hc0; a++) begin
      rchk("ram byte", a, a ^ 8'h5a);
    end
    rchk("port a data", A_PA_DATA, 8'h33);
    i_dmr_cpu_model.bit_wr(8'h00, 1'b1, 3'h0);
    rchk("ram bit set", 8'h00, 8'h5b);
    i_dmr_cpu_model.bit_wr(8'hbf, 1'b0, 3'h0);
    rchk("ram bit clear", 8'hbf, 8'he4);
  endtask

  task automatic t_bits;
    for (int i = 0; i < 11; i++) begin
      i_dmr_cpu_model.wr(BIT_A[i], 8'h0f);
      i_dmr_cpu_model.bit_wr(BIT_A[i], 1'b1, 3'h7);
      i_dmr_cpu_model.bit_wr(BIT_A[i], 1'b0, 3'h0);
      rchk("bit access", BIT_A[i], 8'h8e);
    end
    for (int i = 0; i < 6; i++) begin
      i_dmr_cpu_model.wr(WO_A[i], 8'h3c + 8'(i));
      i_dmr_cpu_model.idle;
      chk("write only", 8'h3c + 8'(i), ctl_regs[WO_A[i][5:0]]);
    end
  endtask

  task automatic t_shared;
    logic [7:0] m;
    logic [7:0] c;
    logic [7:0] t;
    for (int k = 0; k < 2; k++) begin
      m = 8'hd0 + 8'(6 * k);
      t = m + 8'h01;
      i_dmr_cpu_model.wr(m, 8'h00);
      i_dmr_cpu_model.wr(t, 8'h60 + 8'(k));
      i_dmr_cpu_model.idle;
      chk("compare even", 8'h60 + 8'(k), ctl_regs[t[5:0]]);
      rchk("count even", t, 8'h11 + 8'(2 * k));
      i_dmr_cpu_model.wr(m, 8'h20);
      rchk("capture even", t, 8'h21 + 8'(2 * k));
      m = 8'hd2 + 8'(6 * k);
      c = m + 8'h01;
      t = m + 8'h02;
      i_dmr_cpu_model.wr(m, 8'h00);
      i_dmr_cpu_model.wr(c, 8'h70 + 8'(k));
      i_dmr_cpu_model.wr(t, 8'h99);
      i_dmr_cpu_model.idle;
      chk("compare odd", 8'h70 + 8'(k), ctl_regs[c[5:0]]);
      chk("duty held", 8'h00, ctl_regs[t[5:0]]);
      chk("period idle", 8'h00, k ? pwm1_period : pwm0_period);
      rchk("count odd", t, 8'h12 + 8'(2 * k));
      i_dmr_cpu_model.wr(m, 8'h10);
      rchk("capture odd", t, 8'h22 + 8'(2 * k));
      i_dmr_cpu_model.wr(m, 8'h20);
      i_dmr_cpu_model.wr(c, 8'h80 + 8'(k));
      i_dmr_cpu_model.wr(t, 8'h90 + 8'(k));
      i_dmr_cpu_model.idle;
      chk("period", 8'h80 + 8'(k), k ? pwm1_period : pwm0_period);
      chk("compare kept", 8'h70 + 8'(k), ctl_regs[c[5:0]]);
      rchk("period read", c, 8'h00);
      rchk("duty", t, 8'h90 + 8'(k));
    end
    rchk("interval count", A_CLKCTL, 8'h35);
    rchk("adc result", A_ADC_RESULT, 8'h46);
    i_dmr_cpu_model.set_div16;
    i_dmr_cpu_model.idle;
    chk("clock control", 8'h09, ctl_regs[6'h2c]);
    chk("divide select", {5'h00, BTS_DIV16},
        {5'h00, ctl_regs[6'h2c][2:0]});
    rchk("interval kept", A_CLKCTL, 8'h35);
    i_dmr_cpu_model.rd(8'hf0, d, v);
    chk("unassigned strobe", 8'h01, {7'h00, v});
  endtask

  task automatic t_freeze;
    @(negedge clk);
    clk_en = 1'b0;
    i_dmr_cpu_model.wr(A_PD_DATA, 8'ha5);
    i_dmr_cpu_model.idle;
    chk("frozen", 8'h8e, ctl_regs[6'h06]);
    clk_en = 1'b1;
  endtask

  task automatic t_rerst;
    i_dmr_cpu_model.wr(A_BUZZ, 8'h00);
    i_dmr_cpu_model.idle;
    chk("buzzer written", 8'h00, ctl_regs[6'h1e]);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    t_reset;
  endtask

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    pin = '{timer0_count: 8'h11, timer0_capture_data: 8'h21,
            timer1_count: 8'h12, timer1_capture_data: 8'h22,
            timer2_count: 8'h13, timer2_capture_data: 8'h23,
            timer3_count: 8'h14, timer3_capture_data: 8'h24,
            interval_count: 8'h35, adc_result: 8'h46};
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    t_reset;
    t_ram;
    t_bits;
    t_shared;
    t_freeze;
    t_rerst;
    close_out;
  end
endmodule
